/* File: shared/bcs_defs.svh */
// Purpose: Constants for the battery charge sequencer
// Assumes: 100 MHz mclk
// Notes:   Functional notes below list the behaviour kept
//
// Functional notes
// - No charging unless input above undervoltage threshold
// - Battery temperature must be in window first
// - Low battery enters preconditioning after qualification
// - Trickle current equals programmed current over ten
// - Leave precondition above threshold into fast charge
// - At regulation threshold switch to constant voltage
// - Terminate to sleep at 7.5 percent current
// - Sleep until below recharge threshold, then recharge
// - Supply loss sleeps; resume when supply returns
// - Die heating reduces current in fast charge only; restore when allowed
// - Over-voltage or die over-temperature shuts down
// - Battery over-temperature during charge shuts down
// - Faults shown on LEDs and serial status
// - Serial status reports twelve distinct states
// - Two open-drain LED sink outputs
// - Thermal loop starts at 0.44 of programmed
// - Thermal loop steps up every three seconds while die not hot
// - Enable low halts; re-enable requalifies from battery
// - Timeouts: 25 min trickle, 3 h, 3 h CV
`ifndef BCS_DEFS_SVH
`define BCS_DEFS_SVH
// ----------------------------------------------------------
// Timing
// ----------------------------------------------------------
`define BCS_CLK_HZ         100000000
`define BCS_TRICKLE_MIN    25
`define BCS_CC_HOURS       3
`define BCS_CV_HOURS       3
`define BCS_TLOOP_SEC      3
`define BCS_TLOOP_CYC      (`BCS_TLOOP_SEC * `BCS_CLK_HZ)
`define BCS_TRICKLE_CYC    (64'd60 * `BCS_TRICKLE_MIN * `BCS_CLK_HZ)
`define BCS_CC_CYC         (64'd3600 * `BCS_CC_HOURS * `BCS_CLK_HZ)
`define BCS_CV_CYC         (64'd3600 * `BCS_CV_HOURS * `BCS_CLK_HZ)
// Serial status bit time: 20 kHz data rate
`define BCS_BIT_HZ         20000
`define BCS_BIT_CYC        (`BCS_CLK_HZ / `BCS_BIT_HZ)
// ----------------------------------------------------------
// Current scaling: trickle divider, others in 1/1000 of the programmed level
// ----------------------------------------------------------
`define BCS_TRICKLE_DIV    10
`define BCS_TLOOP_START_PM 440
`define BCS_TERM_PM        75
`define BCS_FULL_PM        1000
`define BCS_TLOOP_STEP_PM  40
`endif

/* File: shared/bcs_pkg.sv */
// Purpose: Types for the battery charge sequencer
// Assumes: Used with bcs_defs.svh
// Notes:   Status codes go out on the serial line
package bcs_pkg;
  // Sequencer states
  typedef enum logic [3:0] {
    ST_RESET    = 4'b0000,
    ST_QUAL     = 4'b0001,
    ST_PRECOND  = 4'b0010,
    ST_FAST     = 4'b0011,
    ST_CV       = 4'b0100,
    ST_DONE     = 4'b0101,
    ST_NOSUPPLY = 4'b0110,
    ST_DISABLED = 4'b0111,
    ST_FAULT    = 4'b1000
  } bcs_state_t;

  // Twelve reported charge states
  typedef enum logic [3:0] {
    CS_DISABLED  = 4'h0,
    CS_NO_SUPPLY = 4'h1,
    CS_QUALIFY   = 4'h2,
    CS_PRECOND   = 4'h3,
    CS_FAST      = 4'h4,
    CS_FAST_TLP  = 4'h5,
    CS_CV        = 4'h6,
    CS_DONE      = 4'h7,
    CS_F_OVP     = 4'h8,
    CS_F_DIE     = 4'h9,
    CS_F_BTEMP   = 4'hA,
    CS_F_TIMEOUT = 4'hB
  } bcs_code_t;
endpackage : bcs_pkg

/* File: hw/bcs_sequencer.sv */
// Purpose: Charge sequencer with thermal loop, timers and status
// Assumes: Comparator inputs synchronous to mclk
// Notes:   Current command in 1/1000 of programmed level
`timescale 1ns/1ps
`include "bcs_defs.svh"

module bcs_sequencer #(
  parameter longint TRICKLE_CYC = `BCS_TRICKLE_CYC,
  parameter longint CC_CYC      = `BCS_CC_CYC,
  parameter longint CV_CYC      = `BCS_CV_CYC,
  parameter int     TLOOP_CYC   = `BCS_TLOOP_CYC,
  parameter int     BIT_CYC     = `BCS_BIT_CYC
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // Host control
  input  wire logic        charger_enable_input,
  // Analog comparator results
  input  wire logic        input_above_uvlo,
  input  wire logic        battery_present,
  input  wire logic        battery_temp_sense_ok,
  input  wire logic        battery_node_above_precond,
  input  wire logic        battery_node_at_regulation,
  input  wire logic        battery_node_below_recharge,
  input  wire logic        battery_node_overvoltage,
  input  wire logic        current_below_term,
  input  wire logic        die_hot_loop,
  input  wire logic        die_below_loop_exit,
  input  wire logic        die_overtemp,
  input  wire logic        timer_capacitor_pin_grounded,
  // Pass device command
  output logic             charge_on,
  output logic             cv_mode,
  output logic [9:0]       current_cmd_pm,
  // Status LEDs (open drain sink)
  output logic             led1_oe,
  output logic             led2_oe,
  output logic             led1_out,
  output logic             led2_out,
  // Serial status (open drain, active low)
  output logic             status_data_oe,
  output logic             status_data_out,
  output logic [3:0]       status_code
);

  // ----------------------------------------------------------
  // State registers
  // ----------------------------------------------------------
  bcs_pkg::bcs_state_t state_q, state_d;     // Sequencer state
  bcs_pkg::bcs_code_t  fcode_q, fcode_d;     // Latched fault cause
  logic [39:0]         tmr_q, tmr_d;         // Phase watchdog
  logic [39:0]         lim_q, lim_d;         // Combined trickle+fast timer
  logic                tloop_q, tloop_d;     // Thermal loop active
  logic [9:0]          tlvl_q, tlvl_d;       // Thermal loop level
  logic [31:0]         tcnt_q, tcnt_d;       // Three second interval
  logic                any_fault;            // Live fault present
  logic                tmo_trk, tmo_cc, tmo_cv; // Timeout strobes
  logic                wd_on;                // Watchdog armed

  assign wd_on   = !timer_capacitor_pin_grounded;
  assign tmo_trk = wd_on && (state_q == bcs_pkg::ST_PRECOND) && (tmr_q >= 40'(TRICKLE_CYC));
  // Combined limit only runs in trickle and fast; CV has its own limit
  assign tmo_cc  = wd_on && (state_q == bcs_pkg::ST_PRECOND || state_q == bcs_pkg::ST_FAST)
                && (lim_q >= 40'(CC_CYC));
  assign tmo_cv  = wd_on && (state_q == bcs_pkg::ST_CV) && (tmr_q >= 40'(CV_CYC));
  // Fault sources; battery temperature only counts while charging
  assign any_fault = battery_node_overvoltage || die_overtemp
                  || (charge_on && !battery_temp_sense_ok);

  // ----------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------
  always_comb begin
    state_d = state_q;
    fcode_d = fcode_q;
    tmr_d   = tmr_q + 40'h00_0000_0001;
    lim_d   = lim_q;
    if (!charger_enable_input) begin
      state_d = bcs_pkg::ST_DISABLED;
    end else if (any_fault || tmo_trk || tmo_cc || tmo_cv) begin
      // Faults override every phase except disable
      state_d = bcs_pkg::ST_FAULT;
      if (battery_node_overvoltage) fcode_d = bcs_pkg::CS_F_OVP;
      else if (die_overtemp) fcode_d = bcs_pkg::CS_F_DIE;
      else if (any_fault) fcode_d = bcs_pkg::CS_F_BTEMP;
      else fcode_d = bcs_pkg::CS_F_TIMEOUT;
    end else if (!input_above_uvlo) begin
      state_d = bcs_pkg::ST_NOSUPPLY;
    end else begin
      case (state_q)
        bcs_pkg::ST_RESET, bcs_pkg::ST_DISABLED, bcs_pkg::ST_NOSUPPLY: begin
          state_d = bcs_pkg::ST_QUAL;
        end
        bcs_pkg::ST_QUAL: begin
          // Supply and battery temperature must be qualified
          if (input_above_uvlo && battery_temp_sense_ok && battery_present) begin
            tmr_d = '0;
            lim_d = '0;
            if (!battery_node_above_precond) state_d = bcs_pkg::ST_PRECOND;
            else state_d = bcs_pkg::ST_FAST;
          end
        end
        bcs_pkg::ST_PRECOND: begin
          lim_d = lim_q + 40'h00_0000_0001;
          if (battery_node_above_precond) state_d = bcs_pkg::ST_FAST;
        end
        bcs_pkg::ST_FAST: begin
          lim_d = lim_q + 40'h00_0000_0001;
          if (battery_node_at_regulation) begin
            state_d = bcs_pkg::ST_CV;
            tmr_d   = '0;
          end
        end
        bcs_pkg::ST_CV: begin
          if (current_below_term) state_d = bcs_pkg::ST_DONE;
        end
        bcs_pkg::ST_DONE: begin
          if (battery_node_below_recharge) state_d = bcs_pkg::ST_QUAL;
        end
        bcs_pkg::ST_FAULT: begin
          // Timeout holds until re-enable or supply loss; battery heat until it cools
          if (fcode_q == bcs_pkg::CS_F_TIMEOUT) state_d = bcs_pkg::ST_FAULT;
          else if (fcode_q == bcs_pkg::CS_F_BTEMP && !battery_temp_sense_ok) state_d = bcs_pkg::ST_FAULT;
          else state_d = bcs_pkg::ST_QUAL;
        end
        default: state_d = bcs_pkg::ST_RESET;
      endcase
    end
    if (state_d != bcs_pkg::ST_PRECOND && state_d != bcs_pkg::ST_FAST && state_d != bcs_pkg::ST_CV) begin
      lim_d = '0;
    end
  end

  // Sequencer registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= bcs_pkg::ST_RESET;
      fcode_q <= bcs_pkg::CS_F_OVP;
      tmr_q   <= '0;
      lim_q   <= '0;
    end else begin
      state_q <= state_d;
      fcode_q <= fcode_d;
      tmr_q   <= tmr_d;
      lim_q   <= lim_d;
    end
  end

  // ----------------------------------------------------------
  // Thermal loop: drop to 0.44, step up each interval while die not hot
  // ----------------------------------------------------------
  always_comb begin
    tloop_d = tloop_q;
    tlvl_d  = tlvl_q;
    tcnt_d  = tcnt_q;
    if (state_q != bcs_pkg::ST_FAST) begin
      tloop_d = 1'b0;
      tlvl_d  = 10'(`BCS_FULL_PM);
      tcnt_d  = '0;
    end else if (!tloop_q) begin
      if (die_hot_loop) begin
        tloop_d = 1'b1;
        tlvl_d  = 10'(`BCS_TLOOP_START_PM);
        tcnt_d  = '0;
      end
    end else if (tcnt_q >= 32'(TLOOP_CYC - 1)) begin
      tcnt_d = '0;
      // Re-check die temperature every interval
      if (die_below_loop_exit && tlvl_q >= 10'(`BCS_FULL_PM - `BCS_TLOOP_STEP_PM)) begin
        tloop_d = 1'b0;
        tlvl_d  = 10'(`BCS_FULL_PM);
      end else if (!die_hot_loop && tlvl_q < 10'(`BCS_FULL_PM - `BCS_TLOOP_STEP_PM)) begin
        tlvl_d = tlvl_q + 10'(`BCS_TLOOP_STEP_PM);
      end
    end else begin
      tcnt_d = tcnt_q + 32'h0000_0001;
    end
  end

  // Thermal loop registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      tloop_q <= 1'b0;
      tlvl_q  <= 10'(`BCS_FULL_PM);
      tcnt_q  <= '0;
    end else begin
      tloop_q <= tloop_d;
      tlvl_q  <= tlvl_d;
      tcnt_q  <= tcnt_d;
    end
  end

  // ----------------------------------------------------------
  // Outputs: current command and status code
  // ----------------------------------------------------------
  logic [9:0]         cmd_d;     // Next current command
  logic               on_d;      // Next pass enable
  bcs_pkg::bcs_code_t code_d;    // Next status code
  logic [1:0]         led_d;     // Next LED sinks

  always_comb begin
    cmd_d  = '0;
    on_d   = 1'b0;
    code_d = bcs_pkg::CS_QUALIFY;
    led_d  = 2'b00;
    case (state_q)
      bcs_pkg::ST_PRECOND: begin
        on_d   = 1'b1;
        cmd_d  = 10'(`BCS_FULL_PM / `BCS_TRICKLE_DIV);
        code_d = bcs_pkg::CS_PRECOND;
        led_d  = 2'b01;
      end
      bcs_pkg::ST_FAST: begin
        on_d   = 1'b1;
        cmd_d  = tlvl_q;
        code_d = tloop_q ? bcs_pkg::CS_FAST_TLP : bcs_pkg::CS_FAST;
        led_d  = 2'b01;
      end
      bcs_pkg::ST_CV: begin
        on_d   = 1'b1;
        cmd_d  = 10'(`BCS_FULL_PM);
        code_d = bcs_pkg::CS_CV;
        led_d  = 2'b01;
      end
      bcs_pkg::ST_DONE: begin
        code_d = bcs_pkg::CS_DONE;
        led_d  = 2'b10;
      end
      bcs_pkg::ST_FAULT: begin
        code_d = fcode_q;
        led_d  = 2'b11;
      end
      bcs_pkg::ST_NOSUPPLY: code_d = bcs_pkg::CS_NO_SUPPLY;
      bcs_pkg::ST_DISABLED: code_d = bcs_pkg::CS_DISABLED;
      default: code_d = bcs_pkg::CS_QUALIFY;
    endcase
  end

  // Output registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      current_cmd_pm <= '0;
      charge_on      <= 1'b0;
      cv_mode        <= 1'b0;
      status_code    <= bcs_pkg::CS_QUALIFY;
      led1_oe        <= 1'b0;
      led2_oe        <= 1'b0;
    end else begin
      current_cmd_pm <= cmd_d;
      charge_on      <= on_d;
      cv_mode        <= (state_q == bcs_pkg::ST_CV);
      status_code    <= code_d;
      led1_oe        <= led_d[0];
      led2_oe        <= led_d[1];
    end
  end
  assign led1_out = 1'b0;
  assign led2_out = 1'b0;
  assign status_data_out = 1'b0;

  // ----------------------------------------------------------
  // Serial status: start low, four code bits, idle high
  // ----------------------------------------------------------
  logic [15:0] bc_q, bc_d;     // Bit time counter
  logic [2:0]  bi_q, bi_d;     // Bit index 0..5
  logic [3:0]  sh_q, sh_d;     // Latched code
  logic        so_q, so_d;     // Drive low when set

  always_comb begin
    bc_d = bc_q + 16'h0001;
    bi_d = bi_q;
    sh_d = sh_q;
    so_d = so_q;
    if (bc_q >= 16'(BIT_CYC - 1)) begin
      bc_d = '0;
      if (bi_q == 3'h5) begin
        bi_d = 3'h0;
        sh_d = status_code;
        so_d = 1'b1;
      end else begin
        bi_d = bi_q + 3'h1;
        so_d = (bi_q < 3'h4) ? !sh_q[bi_q[1:0]] : 1'b0;
      end
    end
  end

  // Serial registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      bc_q <= '0;
      bi_q <= 3'h5;
      sh_q <= '0;
      so_q <= 1'b0;
    end else begin
      bc_q <= bc_d;
      bi_q <= bi_d;
      sh_q <= sh_d;
      so_q <= so_d;
    end
  end
  assign status_data_oe = so_q;

  // ----------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------
  a_uvlo_blocks: assert property (@(posedge mclk) disable iff (rst)
    !input_above_uvlo |=> state_q != bcs_pkg::ST_PRECOND && state_q != bcs_pkg::ST_FAST)
    else $error("charging phase entered below uvlo");
  a_trickle_level: assert property (@(posedge mclk) disable iff (rst)
    state_q == bcs_pkg::ST_PRECOND |=> current_cmd_pm == 10'h064)
    else $error("trickle command not one tenth");
  a_disable_halts: assert property (@(posedge mclk) disable iff (rst)
    !charger_enable_input |=> ##1 !charge_on)
    else $error("charging continued while disabled");
  a_ovp_shut: assert property (@(posedge mclk) disable iff (rst)
    charger_enable_input && battery_node_overvoltage |=> state_q == bcs_pkg::ST_FAULT)
    else $error("over-voltage did not shut down");
  a_tloop_start: assert property (@(posedge mclk) disable iff (rst)
    $rose(tloop_q) |-> tlvl_q == 10'h1B8)
    else $error("thermal loop start level wrong");
  a_fault_leds: assert property (@(posedge mclk) disable iff (rst)
    state_q == bcs_pkg::ST_FAULT |=> led1_oe && led2_oe && status_code >= 4'h8)
    else $error("fault not reported");
  a_term_sleep: assert property (@(posedge mclk) disable iff (rst)
    charger_enable_input && input_above_uvlo && !any_fault && !tmo_cv && state_q == bcs_pkg::ST_CV
      && current_below_term |=> state_q == bcs_pkg::ST_DONE)
    else $error("no termination at low current");
  a_cv_entry: assert property (@(posedge mclk) disable iff (rst)
    state_q == bcs_pkg::ST_FAST ##1 state_q == bcs_pkg::ST_CV |=> cv_mode && tmr_q <= 40'h2)
    else $error("cv entry wrong");
  a_code_range: assert property (@(posedge mclk) disable iff (rst)
    status_code <= 4'hB)
    else $error("status code out of range");

endmodule : bcs_sequencer

/* File: verification/bcs_front_end.sv */
// Purpose: Analog sense front end and host status reader model
// Assumes: Levels in mV and degrees C, set by the bench
// Notes:   Serial line has a pull-up; reader keeps a cycle history
`timescale 1ns/1ps
`include "bcs_defs.svh"

module bcs_front_end #(
  parameter int PRECOND_MV = 3000,
  parameter int RECH_MV    = 4100,
  parameter int BIT_CYC    = 4
) (
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rst,
  // Bench-set conditions
  input  wire logic [15:0]          batt_mv,
  input  wire logic [9:0]           cell_pm,
  input  wire logic [7:0]           die_c,
  // Comparator results
  output logic                      above_precond,
  output logic                      at_regulation,
  output logic                      below_recharge,
  output logic                      overvoltage,
  output logic                      below_term,
  output logic                      die_hot,
  output logic                      die_cool,
  output logic                      die_shutdown,
  // Serial status line
  input  wire logic                 data_oe,
  output logic                      data_line,
  output logic [6*BIT_CYC-1:0]      hist_q
);
  // ----------------------------------------------------------
  // Comparators
  // ----------------------------------------------------------
  // Thresholds on bench-set levels
  always_comb begin
    above_precond  = batt_mv > PRECOND_MV;
    at_regulation  = batt_mv >= 16'd4200;
    below_recharge = batt_mv < RECH_MV;
    overvoltage    = batt_mv >= 16'd4400;
    below_term     = cell_pm <= `BCS_TERM_PM;
    die_hot        = die_c >= 8'd110;
    die_cool       = die_c < 8'd85;
    die_shutdown   = die_c >= 8'd145;
  end

  // ----------------------------------------------------------
  // Host reader
  // ----------------------------------------------------------
  // Pull-up: released line reads high
  assign data_line = ~data_oe;

  // One frame of per-cycle samples, oldest at the top
  always_ff @(posedge mclk) begin
    if (rst) begin
      hist_q <= '0;
    end else begin
      hist_q <= {hist_q[6*BIT_CYC-2:0], ~data_line};
    end
  end
endmodule : bcs_front_end

/* File: verification/tb_top.sv */
// Purpose: Scenario bench for the charge sequencer
// Assumes: Short timer parameters
// Notes:   Inputs change 1 ns after the rising edge
`timescale 1ns/1ps

module tb_top;
  localparam int BITC = 4;
  localparam int FRW  = 6 * BITC;
  logic mclk, rst, en, uvlo, pres, tok, ctg;
  logic [15:0] batt;
  logic [9:0] cellp;
  logic [7:0] die;
  wire pre, reg_at, rch, ovp, term, hot, cool, dsd, con, cvm, l1, l2, doe, dln, l1o, l2o, dout;
  wire [9:0] cmd;
  wire [3:0] code;
  wire [FRW-1:0] hist;
  int fails, tests_run, cyc;

  bcs_sequencer #(.TRICKLE_CYC(200), .CC_CYC(1000), .CV_CYC(1000), .TLOOP_CYC(20), .BIT_CYC(BITC)) i_dut (
    .mclk(mclk), .rst(rst), .charger_enable_input(en), .input_above_uvlo(uvlo),
    .battery_present(pres), .battery_temp_sense_ok(tok), .battery_node_above_precond(pre),
    .battery_node_at_regulation(reg_at), .battery_node_below_recharge(rch),
    .battery_node_overvoltage(ovp), .current_below_term(term), .die_hot_loop(hot),
    .die_below_loop_exit(cool), .die_overtemp(dsd), .timer_capacitor_pin_grounded(ctg),
    .charge_on(con), .cv_mode(cvm), .current_cmd_pm(cmd), .led1_oe(l1), .led2_oe(l2),
    .led1_out(l1o), .led2_out(l2o), .status_data_oe(doe), .status_data_out(dout), .status_code(code));

  bcs_front_end #(.BIT_CYC(BITC)) i_fe (
    .mclk(mclk), .rst(rst), .batt_mv(batt), .cell_pm(cellp), .die_c(die),
    .above_precond(pre), .at_regulation(reg_at), .below_recharge(rch), .overvoltage(ovp),
    .below_term(term), .die_hot(hot), .die_cool(cool), .die_shutdown(dsd),
    .data_oe(doe), .data_line(dln), .hist_q(hist));

  // Clock, 10 ns period
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 30000) begin
      fails++;
      close_out();
    end
  end

  // ----------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------
  task tick(input int n);
    repeat (n) begin
      @(posedge mclk);
      #1;
    end
  endtask : tick

  task chk(input string nm, input logic [9:0] exp, input logic [9:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk

  // Bounded wait for a status code, then judge it
  task wait_code(input logic [3:0] c, input int lim);
    int n;
    n = 0;
    while (code !== c && n < lim) begin
      tick(1);
      n++;
    end
    chk("status_code", c, code);
  endtask : wait_code

  task wait_cmd(input logic [9:0] v, input int lim);
    int n;
    n = 0;
    while (cmd !== v && n < lim) begin
      tick(1);
      n++;
    end
    chk("current_cmd_pm", v, cmd);
  endtask : wait_cmd

  // Start low, code bits low for 0, LSB first, then idle
  task chk_frame(input logic [3:0] c);
    logic [5:0] b;
    logic [FRW-1:0] p;
    int n;
    b = {1'b1, ~c[0], ~c[1], ~c[2], ~c[3], 1'b0};
    for (int k = 0; k < 6; k++) begin
      for (int j = 0; j < BITC; j++) p[FRW-1-k*BITC-j] = b[5-k];
    end
    n = 0;
    while (hist !== p && n < 3 * FRW) begin
      tick(1);
      n++;
    end
    tests_run++;
    if (hist !== p) begin
      fails++;
      $display("[ERR] serial_frame expected %h seen %h", p, hist);
    end
  endtask : chk_frame

  task close_out;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out

  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  // Full cycle: trickle, fast, CV, done, recharge
  task t_walk;
    batt = 16'd2500;
    wait_code(bcs_pkg::CS_PRECOND, 20);
    chk("current_cmd_pm", 10'd100, cmd);
    chk("charge_on", 1'b1, con);
    chk("led1_oe", 1'b1, l1);
    batt = 16'd3600;
    wait_code(bcs_pkg::CS_FAST, 10);
    chk("current_cmd_pm", 10'd1000, cmd);
    batt = 16'd4200;
    wait_code(bcs_pkg::CS_CV, 10);
    chk("cv_mode", 1'b1, cvm);
    cellp = 10'd76;
    tick(10);
    chk("status_code", bcs_pkg::CS_CV, code);
    cellp = 10'd75;
    wait_code(bcs_pkg::CS_DONE, 10);
    chk("charge_on", 1'b0, con);
    chk("leds", 2'b01, {l1, l2});
    batt = 16'd4150;
    tick(20);
    chk("status_code", bcs_pkg::CS_DONE, code);
    batt = 16'd4000;
    cellp = 10'd500;
    wait_code(bcs_pkg::CS_FAST, 10);
    chk_frame(bcs_pkg::CS_FAST);
  endtask : t_walk

  // Supply loss, temperature and presence qualification
  task t_quals;
    uvlo = 1'b0;
    wait_code(bcs_pkg::CS_NO_SUPPLY, 10);
    chk("charge_on", 1'b0, con);
    tok = 1'b0;
    uvlo = 1'b1;
    tick(20);
    chk("status_code", bcs_pkg::CS_QUALIFY, code);
    chk_frame(bcs_pkg::CS_QUALIFY);
    tok = 1'b1;
    pres = 1'b0;
    tick(20);
    chk("charge_on", 1'b0, con);
    pres = 1'b1;
    wait_code(bcs_pkg::CS_FAST, 10);
  endtask : t_quals

  // Thermal loop entry, hold, step-up and exit
  task t_tloop;
    die = 8'd120;
    wait_code(bcs_pkg::CS_FAST_TLP, 10);
    chk("current_cmd_pm", 10'd440, cmd);
    tick(60);
    chk("current_cmd_pm", 10'd440, cmd);
    die = 8'd100;
    wait_cmd(10'd480, 45);
    die = 8'd80;
    wait_code(bcs_pkg::CS_FAST, 400);
    chk("current_cmd_pm", 10'd1000, cmd);
  endtask : t_tloop

  // Over-voltage, die and battery temperature faults: shutdown, both LEDs, serial code, recovery
  task t_faults;
    logic [3:0] fc [3];
    fc = '{bcs_pkg::CS_F_OVP, bcs_pkg::CS_F_DIE, bcs_pkg::CS_F_BTEMP};
    for (int i = 0; i < 3; i++) begin
      if (i == 0) batt = 16'd4500;
      if (i == 1) die = 8'd150;
      if (i == 2) tok = 1'b0;
      wait_code(fc[i], 10);
      chk("charge_on", 1'b0, con);
      chk("leds", 2'b11, {l1, l2});
      chk("sink_levels", 10'h000, {l1o, l2o, dout});
      chk_frame(fc[i]);
      batt = 16'd4000;
      die = 8'd25;
      tok = 1'b1;
      wait_code(bcs_pkg::CS_FAST, 10);
    end
  endtask : t_faults

  // Enable cycling and trickle watchdog
  task t_timer;
    en = 1'b0;
    wait_code(bcs_pkg::CS_DISABLED, 10);
    chk("charge_on", 1'b0, con);
    batt = 16'd2500;
    en = 1'b1;
    wait_code(bcs_pkg::CS_PRECOND, 10);
    tick(150);
    chk("status_code", bcs_pkg::CS_PRECOND, code);
    wait_code(bcs_pkg::CS_F_TIMEOUT, 80);
    tick(20);
    chk("status_code", bcs_pkg::CS_F_TIMEOUT, code);
    chk("charge_on", 1'b0, con);
    ctg = 1'b1;
    en = 1'b0;
    tick(5);
    en = 1'b1;
    wait_code(bcs_pkg::CS_PRECOND, 10);
    tick(400);
    chk("status_code", bcs_pkg::CS_PRECOND, code);
  endtask : t_timer

  // Main sequence; bench drives enable like the host would
  initial begin
    rst = 1'b1;
    en = 1'b1;
    uvlo = 1'b1;
    pres = 1'b1;
    tok = 1'b1;
    ctg = 1'b0;
    batt = 16'd2500;
    cellp = 10'd500;
    die = 8'd25;
    tick(3);
    chk("status_code", bcs_pkg::CS_QUALIFY, code);
    rst = 1'b0;
    t_walk();
    t_quals();
    t_tloop();
    t_faults();
    t_timer();
    close_out();
  end
endmodule : tb_top
